// ### cslt_pkg.sv
// constants and types for the strap latch and pin configuration block
// assumes one core clock and an active-low asynchronous reset
// Function
// - capture every strap when reset releases; hold it as default afterwards
// - mode code weak pull-down selects bus master for i2c bridging
// - mode code weak pull-up selects bus slave for hub configuration
// - per port 1-6, each disable strap 0 means enabled; one strap at 1 alone leaves the port enabled
// - port disabled only when both D+ and D- straps are high
// - disabling the usb 2.0 side also disables the usb 3 side
// - fixed port strap: none, 3, 3-4, 3-5, 3-6, then reserved
// - charging strap: none, 1, 1-2, 1-3, 1-4, 1-6
// - each general pin is input or output; outputs drive low or high
// - each input pin selects internal pull-down or pull-up; reset holds both pulls off until the first edge after release
// - runtime pin writes come from slave bus or usb bridging
// - usb bridging requests are applied as pin configuration writes
package cslt_pkg;
  // ==========================================================
  // strap level codes
  localparam logic [2:0] LVL_WEAK_PD   = 3'h0;
  localparam logic [2:0] LVL_WEAK_PU   = 3'h1;
  localparam logic [2:0] LVL_MED_PD    = 3'h2;
  localparam logic [2:0] LVL_MED_PU    = 3'h3;
  localparam logic [2:0] LVL_STRONG_PD = 3'h4;
  localparam logic [2:0] LVL_STRONG_PU = 3'h5;
  // ==========================================================
  // sizes and reset values
  localparam int         NUM_PORTS     = 6;
  localparam int         NUM_PINS      = 8;
  localparam logic [2:0] RST_CODE      = 3'h0;
  localparam logic [5:0] RST_PORTS     = 6'h00;
  localparam logic [7:0] RST_PINS      = 8'h00;
  // ==========================================================
  // latch sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_HOLD = 3'b100
  } cslt_state_type;
endpackage

// ### cslt_strap_latch.sv
// strap latch, decoder and general pin configuration registers
// assumes straps and levels are pins (synchronised here); write ports
// come from logic on clk_sys
module cslt_strap_latch (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // strap pins
  input  wire logic [2:0] modeStrap,
  input  wire logic [5:0] port_dplus_disable_strap,
  input  wire logic [5:0] port_dminus_disable_strap,
  input  wire logic [2:0] fixed_port_count_strap,
  input  wire logic [2:0] charging_ports_strap,
  // runtime pin configuration writes
  input  wire logic       slaveWrEn,
  input  wire logic [7:0] slaveWrDir,
  input  wire logic [7:0] slaveWrLevel,
  input  wire logic [7:0] slaveWrPullUp,
  input  wire logic       bridgeWrEn,
  input  wire logic [7:0] bridgeWrDir,
  input  wire logic [7:0] bridgeWrLevel,
  input  wire logic [7:0] bridgeWrPullUp,
  // general pins
  input  wire logic [7:0] general_pin_in,
  output logic      [7:0] general_pin_out,
  output logic      [7:0] general_pin_oe,
  output logic      [7:0] pinPullUpEn,
  output logic      [7:0] pinPullDownEn,
  output logic      [7:0] pinInputLevel,
  // decoded settings
  output logic            strapsValid,
  output logic            bridge_master_setting,
  output logic            config_slave_setting,
  output logic            modeReserved,
  output logic      [2:0] modeCode,
  output logic      [5:0] usb2PortDisabled,
  output logic      [5:0] usb3PortDisabled,
  output logic      [5:0] fixedPorts,
  output logic            fixedReserved,
  output logic      [5:0] chargingPorts
);
  // all checks below run on the core clock and rest during reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // input synchronisers, two flops each
  logic [20:0] syncA;
  logic [20:0] syncB;
  logic [7:0]  pinA;
  // strap flops carry no reset: they must already hold the pin levels
  // when reset releases, since capture reads them two edges later
  always_ff @(posedge clk_sys) begin
    syncA <= {modeStrap, port_dplus_disable_strap,
              port_dminus_disable_strap, fixed_port_count_strap,
              charging_ports_strap};
    syncB <= syncA;
  end
  // general pin levels, cleared by reset like every other output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pinA          <= cslt_pkg::RST_PINS;
      pinInputLevel <= cslt_pkg::RST_PINS;
    end else begin
      pinA          <= general_pin_in;
      pinInputLevel <= pinA;
    end
  end
  wire logic [2:0] sMode  = syncB[20:18];
  wire logic [5:0] sDisP  = syncB[17:12];
  wire logic [5:0] sDisM  = syncB[11:6];
  wire logic [2:0] sFixed = syncB[5:3];
  wire logic [2:0] sChg   = syncB[2:0];

  // ==========================================================
  // capture sequencer: one capture after reset release, then hold
  // reset itself cannot sample a port, so capture waits for sync depth
  cslt_pkg::cslt_state_type state;
  cslt_pkg::cslt_state_type next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      cslt_pkg::ST_RESET:   next_state = cslt_pkg::ST_CAPTURE;
      cslt_pkg::ST_CAPTURE: next_state = cslt_pkg::ST_HOLD;
      cslt_pkg::ST_HOLD:    next_state = cslt_pkg::ST_HOLD;
      default:              next_state = cslt_pkg::ST_RESET;
    endcase
  end
  wire logic capture = (state == cslt_pkg::ST_CAPTURE);

  // ==========================================================
  // decode of synchronised straps
  logic       next_bm, next_cs, next_mr, next_fr;
  logic [5:0] next_u2, next_fx, next_ch;
  always_comb begin
    next_bm = (sMode == cslt_pkg::LVL_WEAK_PD);
    next_cs = (sMode == cslt_pkg::LVL_WEAK_PU);
    next_mr = !next_bm && !next_cs;
    next_u2 = sDisP & sDisM;
    next_fr = 1'b0;
    unique case (sFixed)
      cslt_pkg::LVL_WEAK_PD:   next_fx = 6'h00;
      cslt_pkg::LVL_WEAK_PU:   next_fx = 6'h04;
      cslt_pkg::LVL_MED_PD:    next_fx = 6'h0c;
      cslt_pkg::LVL_MED_PU:    next_fx = 6'h1c;
      cslt_pkg::LVL_STRONG_PD: next_fx = 6'h3c;
      default: begin
        next_fx = 6'h00;
        next_fr = 1'b1;
      end
    endcase
    unique case (sChg)
      cslt_pkg::LVL_WEAK_PU:   next_ch = 6'h01;
      cslt_pkg::LVL_MED_PD:    next_ch = 6'h03;
      cslt_pkg::LVL_MED_PU:    next_ch = 6'h07;
      cslt_pkg::LVL_STRONG_PD: next_ch = 6'h0f;
      cslt_pkg::LVL_STRONG_PU: next_ch = 6'h3f;
      default:                 next_ch = 6'h00;
    endcase
  end

  // next values of the latched settings: they move only in the single
  // capture cycle, so strap pins reused later cannot disturb them
  logic       next_valid;
  logic       next_master;
  logic       next_slave;
  logic       next_modeRes;
  logic [2:0] next_modeCode;
  logic [5:0] next_usb2;
  logic [5:0] next_usb3;
  logic [5:0] next_fixed;
  logic       next_fixedRes;
  logic [5:0] next_charging;
  always_comb begin
    next_valid    = strapsValid;
    next_master   = bridge_master_setting;
    next_slave    = config_slave_setting;
    next_modeRes  = modeReserved;
    next_modeCode = modeCode;
    next_usb2     = usb2PortDisabled;
    next_usb3     = usb3PortDisabled;
    next_fixed    = fixedPorts;
    next_fixedRes = fixedReserved;
    next_charging = chargingPorts;
    if (capture) begin
      next_valid    = 1'b1;
      next_master   = next_bm;
      next_slave    = next_cs;
      next_modeRes  = next_mr;
      next_modeCode = sMode;
      next_usb2     = next_u2;
      next_usb3     = next_u2;
      next_fixed    = next_fx;
      next_fixedRes = next_fr;
      next_charging = next_ch;
    end
  end

  // sequencer and latched settings, registered only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state                 <= cslt_pkg::ST_RESET;
      strapsValid           <= 1'b0;
      bridge_master_setting <= 1'b0;
      config_slave_setting  <= 1'b0;
      modeReserved          <= 1'b0;
      modeCode              <= cslt_pkg::RST_CODE;
      usb2PortDisabled      <= cslt_pkg::RST_PORTS;
      usb3PortDisabled      <= cslt_pkg::RST_PORTS;
      fixedPorts            <= cslt_pkg::RST_PORTS;
      fixedReserved         <= 1'b0;
      chargingPorts         <= cslt_pkg::RST_PORTS;
    end else begin
      state                 <= next_state;
      strapsValid           <= next_valid;
      bridge_master_setting <= next_master;
      config_slave_setting  <= next_slave;
      modeReserved          <= next_modeRes;
      modeCode              <= next_modeCode;
      usb2PortDisabled      <= next_usb2;
      usb3PortDisabled      <= next_usb3;
      fixedPorts            <= next_fixed;
      fixedReserved         <= next_fixedRes;
      chargingPorts         <= next_charging;
    end
  end

  // ==========================================================
  // general pin configuration; slave write wins if both in one cycle
  // pulls only act on input pins, so an output never fights its pull
  logic [7:0] next_dir, next_lvl, next_pu, next_pue, next_pde;
  always_comb begin
    next_dir = general_pin_oe;
    next_lvl = general_pin_out;
    next_pu  = pinPullUpEn;
    if (slaveWrEn) begin
      next_dir = slaveWrDir;
      next_lvl = slaveWrLevel;
      next_pu  = slaveWrPullUp;
    end else if (bridgeWrEn) begin
      next_dir = bridgeWrDir;
      next_lvl = bridgeWrLevel;
      next_pu  = bridgeWrPullUp;
    end
    next_pue = next_pu & ~next_dir;
    next_pde = ~next_pu & ~next_dir;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      general_pin_oe  <= cslt_pkg::RST_PINS;
      general_pin_out <= cslt_pkg::RST_PINS;
      pinPullUpEn     <= cslt_pkg::RST_PINS;
      pinPullDownEn   <= cslt_pkg::RST_PINS;
    end else begin
      general_pin_oe  <= next_dir;
      general_pin_out <= next_lvl;
      pinPullUpEn     <= next_pue;
      pinPullDownEn   <= next_pde;
    end
  end

  // ==========================================================
  // checks
  // release, one edge while the synchronisers settle, the capture edge
  sequence s_sync_wait;
    !capture && !strapsValid;
  endsequence
  sequence s_capture_edge;
    capture && !strapsValid;
  endsequence
  chk_capture_timing: assert property ($rose(arst_n) |->
    s_sync_wait ##1 s_capture_edge ##1 strapsValid)
    else $error("straps not captured two edges after release");
  chk_capture_once: assert property (strapsValid |=>
    strapsValid && $stable(modeCode))
    else $error("latched mode changed after capture");
  chk_master_role: assert property (capture && sMode == 3'h0 |=>
    bridge_master_setting && !config_slave_setting)
    else $error("master role not latched");
  chk_slave_role: assert property (capture && sMode == 3'h1 |=>
    config_slave_setting && !bridge_master_setting)
    else $error("slave role not latched");
  chk_reserved_mode: assert property (strapsValid |->
    modeReserved == (modeCode > 3'h1)
      && !(modeReserved && (bridge_master_setting || config_slave_setting)))
    else $error("reserved mode flag wrong");
  chk_port_both: assert property (capture |=>
    usb2PortDisabled == ($past(sDisP) & $past(sDisM)))
    else $error("port disable not both straps");
  chk_usb3_follow: assert property (
    usb3PortDisabled == usb2PortDisabled)
    else $error("usb3 side not following");
  chk_fixed_order: assert property (capture && sFixed == 3'h3 |=>
    fixedPorts == 6'h1c)
    else $error("fixed port decode wrong");
  chk_fixed_resv: assert property (capture && sFixed == 3'h5 |=>
    fixedReserved && fixedPorts == 6'h00)
    else $error("reserved fixed code not flagged");
  chk_charge_all: assert property (capture && sChg == 3'h5 |=>
    chargingPorts == 6'h3f)
    else $error("charging decode wrong");
  chk_pin_write: assert property (!slaveWrEn && bridgeWrEn |=>
    general_pin_oe == $past(bridgeWrDir)
      && general_pin_out == $past(bridgeWrLevel))
    else $error("bridge write not applied");
  chk_slave_write: assert property (slaveWrEn |=>
    general_pin_oe == $past(slaveWrDir)
      && general_pin_out == $past(slaveWrLevel))
    else $error("slave write not applied");
  chk_pull_excl: assert property (
    (pinPullUpEn & pinPullDownEn) == 8'h00
      && (pinPullUpEn & general_pin_oe) == 8'h00)
    else $error("pull selection conflict");
endmodule

// ### cslt_board_model.sv
// board straps and reset source facing the strap latch
// assumes the bench sets the wanted levels and raises go
module cslt_board_model (
  // clock and sequencing
  input  wire logic       clk_sys,
  input  wire logic       go,
  output logic            done,
  // wanted strap levels
  input  wire logic [2:0] wMode,
  input  wire logic [2:0] wFix,
  input  wire logic [2:0] wChg,
  input  wire logic [5:0] wDp,
  input  wire logic [5:0] wDm,
  // reset and strap pins
  output logic            arst_n,
  output logic      [20:0] straps
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // reset pulse with straps settled around the release
  initial begin
    arst_n = 1'b0;
    done = 1'b0;
  end
  always begin
    wait (go);
    arst_n = 1'b0;
    straps = {wMode, wFix, wChg, wDp, wDm}; // 3-bit codes, both lines
    repeat (3) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    // hold past capture, then pins go to other use: show the inverse
    repeat (4) @(posedge clk_sys);
    #1 straps = ~straps;
    done = 1'b1;
    wait (!go);
    done = 1'b0;
  end
endmodule

// ### test_config_strap_latch_decoder.sv
// self-checking bench for the strap latch and general pin registers
// assumes the board model owns reset and strap pins
module test_config_strap_latch_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus and observed signals
  logic        clk_sys = 1'b0;
  logic        go = 1'b0;
  logic        done, arst_n, slvEn = 1'b0, brgEn = 1'b0;
  logic [2:0]  wMode, wFix, wChg, modeCode;
  logic [5:0]  wDp, wDm, u2Dis, u3Dis, fixPorts, chgPorts;
  logic [20:0] straps;
  logic [7:0]  sDir = '0, sLvl = '0, sPu = '0, bDir = '0, bLvl = '0, bPu = '0;
  logic [7:0]  pinIn = '0, pinOut, pinOe, puEn, pdEn, inLvl;
  logic [7:0]  eDir, eLvl, ePu, h1;
  logic        valid, master, slave, modeRes, fixRes;
  int          n_errors = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  cslt_board_model i_board (.clk_sys(clk_sys), .go(go), .done(done),
    .wMode(wMode), .wFix(wFix), .wChg(wChg), .wDp(wDp), .wDm(wDm),
    .arst_n(arst_n), .straps(straps));
  cslt_strap_latch i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .modeStrap(straps[20:18]), .fixed_port_count_strap(straps[17:15]),
    .charging_ports_strap(straps[14:12]),
    .port_dplus_disable_strap(straps[11:6]),
    .port_dminus_disable_strap(straps[5:0]),
    .slaveWrEn(slvEn), .slaveWrDir(sDir), .slaveWrLevel(sLvl),
    .slaveWrPullUp(sPu), .bridgeWrEn(brgEn), .bridgeWrDir(bDir),
    .bridgeWrLevel(bLvl), .bridgeWrPullUp(bPu), .general_pin_in(pinIn),
    .general_pin_out(pinOut), .general_pin_oe(pinOe), .pinPullUpEn(puEn),
    .pinPullDownEn(pdEn), .pinInputLevel(inLvl), .strapsValid(valid),
    .bridge_master_setting(master), .config_slave_setting(slave),
    .modeReserved(modeRes), .modeCode(modeCode),
    .usb2PortDisabled(u2Dis), .usb3PortDisabled(u3Dis),
    .fixedPorts(fixPorts), .fixedReserved(fixRes),
    .chargingPorts(chgPorts));
  // ==========================================================
  // comparison, expectations and closing
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] fix_exp(input logic [2:0] c);
    // code c up to 4 marks ports 3 up to c+2 as fixed (bit 2 is port 3); higher codes mark none
    fix_exp = (c > 3'h4) ? 6'h00 : 6'(((6'h01 << c) - 6'h01) << 2);
  endfunction
  function automatic logic [5:0] chg_exp(input logic [2:0] c);
    chg_exp = (c == 3'h5) ? 6'h3f : (c > 3'h5) ? 6'h00 : 6'((1 << c) - 1);
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // decoded settings must match the levels seen at release
  task automatic check_straps;
    check(8'(valid), 8'h01);
    check(8'(master), 8'(wMode == 3'h0));
    check(8'(slave), 8'(wMode == 3'h1));
    check(8'({modeRes, modeCode}), 8'({wMode > 3'h1, wMode}));
    check(8'(u2Dis), 8'(wDp & wDm));
    check(8'(u3Dis), 8'(wDp & wDm));
    check(8'({fixRes, fixPorts}), 8'({wFix > 3'h4, fix_exp(wFix)}));
    check(8'(chgPorts), 8'(chg_exp(wChg)));
  endtask
  task automatic strap_run(input logic [2:0] c, input logic [5:0] p, n);
    {wMode, wFix, wChg, wDp, wDm} = {c, c, c, p, n};
    {eDir, eLvl, ePu} = '0;
    go = 1'b1;
    #2 check(8'(valid), 8'h00);
    check(pinOe, 8'h00);
    check(pdEn, 8'h00);
    wait (done);
    #1 go = 1'b0;
    check_straps;
  endtask
  // random back-to-back writes, both sources at once now and then;
  // each write is driven just after an edge and checked after the next
  task automatic pin_traffic(input int n);
    @(posedge clk_sys);
    #1;
    repeat (n) begin
      {slvEn, brgEn} = 2'($urandom);
      {sDir, sLvl, sPu, bDir, bLvl, bPu} = 48'({$urandom, $urandom});
      h1 = pinIn;
      pinIn = 8'($urandom);
      if (slvEn) {eDir, eLvl, ePu} = {sDir, sLvl, sPu};
      else if (brgEn) {eDir, eLvl, ePu} = {bDir, bLvl, bPu};
      @(posedge clk_sys);
      #1 check(pinOe, eDir);
      check(pinOut, eLvl);
      check(puEn, ePu & ~eDir);
      check(pdEn, ~ePu & ~eDir);
      check(inLvl, h1);
    end
    {slvEn, brgEn} = 2'b00;
    check_straps;
  endtask
  // ==========================================================
  // every code of the mode, fixed and charging straps, then random straps
  initial begin
    void'($urandom(15));
    for (int i = 0; i < 8; i++) begin
      strap_run(3'(i), (i < 2) ? 6'h3f : 6'($urandom),
                (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($urandom));
      pin_traffic(20);
    end
    repeat (4) begin
      strap_run(3'($urandom), 6'($urandom), 6'($urandom));
      pin_traffic(20);
    end
    results;
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_errors++;
    results;
  end
endmodule
